// File: hdl/ptpsy_sync_engine.sv
`timescale 1ns/1ps
module ptpsy_sync_engine #(
	parameter int unsigned SYNC_CYC = ptpsy_pkg::SYNC_PERIOD_CYC,
	parameter int unsigned ANNOUNCE_CYC = ptpsy_pkg::ANNOUNCE_PERIOD_CYC,
	parameter int unsigned TIMEOUT_CYC = ptpsy_pkg::ANNOUNCE_TIMEOUT_CYC,
	parameter int unsigned PDELAY_CYC = ptpsy_pkg::PDELAY_PERIOD_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Local time
	input wire ptpsy_pkg::ptpsy_ts_t local_time,
	// Configuration
	input wire logic cfg_p2p,
	input wire logic cfg_master_capable,
	input wire logic cfg_two_step,
	input wire logic [ptpsy_pkg::QUAL_W-1:0] cfg_quality,
	// Frame reference strobes
	input wire logic rx_sfd,
	input wire logic tx_sfd,
	// Received messages
	input wire logic rx_msg_valid,
	input wire ptpsy_pkg::ptpsy_msg_t rx_msg_type,
	input wire logic [ptpsy_pkg::SEQ_W-1:0] rx_msg_seq,
	input wire ptpsy_pkg::ptpsy_ts_t rx_msg_ts,
	input wire ptpsy_pkg::ptpsy_ts_t rx_msg_ts2,
	input wire logic rx_msg_two_step,
	input wire logic [ptpsy_pkg::QUAL_W-1:0] rx_msg_quality,
	// Transmit requests
	output logic tx_msg_valid,
	input wire logic tx_msg_ready,
	output ptpsy_pkg::ptpsy_msg_t tx_msg_type,
	output logic [ptpsy_pkg::SEQ_W-1:0] tx_msg_seq,
	output ptpsy_pkg::ptpsy_ts_t tx_msg_ts,
	output logic tx_msg_two_step,
	output ptpsy_pkg::ptpsy_ts_t tx_onfly_ts,
	output logic tx_onfly_valid,
	// Results
	output logic is_master,
	output ptpsy_pkg::ptpsy_ts_t path_delay,
	output logic delay_valid,
	output ptpsy_pkg::ptpsy_ts_t phase_offset,
	output logic phase_adj,
	output logic signed [31:0] drift,
	output logic freq_adj
);
	import ptpsy_pkg::*;

	// ==========================================
	// State
	typedef struct packed {
		ptpsy_role_t role;
		logic [CNT_W-1:0] ann_cnt;
		logic [CNT_W-1:0] sync_cnt;
		logic [CNT_W-1:0] tout_cnt;
		logic [CNT_W-1:0] req_cnt;
		logic pend_sync;
		logic pend_ann;
		logic pend_fu;
		logic pend_dresp;
		logic pend_dreq;
		logic pend_preq;
		logic pend_presp;
		logic pend_pfu;
		ptpsy_txp_t txp;
		ptpsy_msg_t tx_type;
		logic [SEQ_W-1:0] tx_seq;
		ptpsy_ts_t tx_ts;
		logic tx_two;
		ptpsy_ts_t onfly_ts;
		logic onfly_valid;
		ptpsy_ts_t rx_stamp;
		logic [SEQ_W-1:0] sync_seq;
		logic [SEQ_W-1:0] req_seq;
		logic [SEQ_W-1:0] resp_seq;
		ptpsy_ts_t resp_ts;
		ptpsy_ts_t fu_ts;
		ptpsy_ts_t sync_tx_time;
		ptpsy_ts_t sync_rx_time;
		ptpsy_ts_t prev_sync_tx_time;
		ptpsy_ts_t prev_sync_rx_time;
		logic have_prev;
		logic wait_fu;
		logic wait_pfu;
		ptpsy_ts_t delay_req_tx_time;
		ptpsy_ts_t delay_req_rx_time;
		ptpsy_ts_t pdelay_resp_tx_time;
		ptpsy_ts_t pdelay_resp_rx_time;
		ptpsy_ts_t delay;
		logic delay_ok;
		ptpsy_ts_t offset;
		logic phase_adj;
		logic signed [31:0] drift;
		logic freq_adj;
		logic div_busy;
		logic [5:0] div_cnt;
		logic [32:0] div_rem;
		logic [31:0] div_den;
		logic [31:0] div_q;
		logic div_neg;
	} ptpsy_state_t;

	ptpsy_state_t s;
	ptpsy_state_t n;

	always_comb begin
		logic sync_pair;
		logic e2e_done;
		logic p2p_done;
		logic signed [32:0] span_diff;
		logic [32:0] span_mag;
		logic [32:0] rem2;
		sync_pair = 1'b0;
		e2e_done = 1'b0;
		p2p_done = 1'b0;
		span_diff = '0;
		span_mag = '0;
		rem2 = '0;
		n = s;
		n.phase_adj = 1'b0;
		n.freq_adj = 1'b0;
		n.onfly_valid = 1'b0;

		// ==========================================
		// Reference stamps at the delimiter
		if (rx_sfd) begin
			n.rx_stamp = local_time; // [RULE_17]
		end

		// ==========================================
		// Transmit: selection clears pending flags before events set them, so a set wins
		case (s.txp)
			TX_IDLE: begin
				n.txp = TX_OFFER;
				n.tx_two = 1'b0;
				n.tx_ts = TS_RESET;
				if (s.pend_fu) begin
					n.pend_fu = 1'b0;
					n.tx_type = MSG_FOLLOW_UP;
					n.tx_seq = s.sync_seq;
					n.tx_ts = s.fu_ts; // [RULE_01]
				end else if (s.pend_pfu) begin
					n.pend_pfu = 1'b0;
					n.tx_type = MSG_PDELAY_RESP_FU;
					n.tx_seq = s.resp_seq;
					n.tx_ts = s.fu_ts; // [RULE_06]
				end else if (s.pend_dresp) begin
					n.pend_dresp = 1'b0;
					n.tx_type = MSG_DELAY_RESP;
					n.tx_seq = s.resp_seq;
					n.tx_ts = s.resp_ts; // [RULE_04]
				end else if (s.pend_presp) begin
					n.pend_presp = 1'b0;
					n.tx_type = MSG_PDELAY_RESP;
					n.tx_seq = s.resp_seq;
					n.tx_ts = s.resp_ts; // [RULE_06]
					n.tx_two = cfg_two_step;
				end else if (s.pend_sync) begin
					n.pend_sync = 1'b0;
					n.tx_type = MSG_SYNC;
					n.sync_seq = s.sync_seq + 16'h0001;
					n.tx_seq = s.sync_seq + 16'h0001;
					n.tx_two = cfg_two_step;
				end else if (s.pend_ann) begin
					n.pend_ann = 1'b0;
					n.tx_type = MSG_ANNOUNCE;
					n.tx_seq = s.sync_seq;
				end else if (s.pend_dreq || s.pend_preq) begin
					n.tx_type = s.pend_dreq ? MSG_DELAY_REQ : MSG_PDELAY_REQ;
					n.pend_dreq = 1'b0;
					n.pend_preq = 1'b0;
					n.req_seq = s.req_seq + 16'h0001;
					n.tx_seq = s.req_seq + 16'h0001;
				end else begin
					n.txp = TX_IDLE;
				end
			end
			TX_OFFER: begin
				if (tx_msg_ready) begin
					n.txp = TX_STAMP;
				end
			end
			TX_STAMP: begin
				if (tx_sfd) begin
					n.txp = TX_IDLE;
					n.onfly_ts = local_time; // [RULE_17]
					n.onfly_valid = 1'b1;
					case (s.tx_type)
						MSG_SYNC: begin
							n.fu_ts = local_time; // [RULE_01]
							n.pend_fu = s.tx_two;
						end
						MSG_DELAY_REQ, MSG_PDELAY_REQ: begin
							n.delay_req_tx_time = local_time; // [RULE_03] [RULE_05]
						end
						MSG_PDELAY_RESP: begin
							n.fu_ts = local_time; // [RULE_06]
							n.pend_pfu = s.tx_two;
						end
						default: begin
						end
					endcase
				end
			end
			default: begin
				n.txp = TX_IDLE;
			end
		endcase

		// ==========================================
		// Periodic duties and role
		if (s.role == ROLE_MASTER) begin
			n.tout_cnt = '0;
			n.ann_cnt = s.ann_cnt + 32'h0000_0001;
			n.sync_cnt = s.sync_cnt + 32'h0000_0001;
			if (s.ann_cnt >= 32'(ANNOUNCE_CYC - 1)) begin
				n.ann_cnt = '0;
				n.pend_ann = 1'b1; // [RULE_14] [RULE_16]
			end
			if (s.sync_cnt >= 32'(SYNC_CYC - 1)) begin
				n.sync_cnt = '0;
				n.pend_sync = 1'b1; // [RULE_15] [RULE_16]
			end
			if (!cfg_master_capable) begin
				n.role = ROLE_SLAVE;
			end
		end else begin
			n.ann_cnt = '0;
			n.sync_cnt = '0;
			n.tout_cnt = s.tout_cnt + 32'h0000_0001;
			if (s.tout_cnt >= 32'(TIMEOUT_CYC - 1) && cfg_master_capable) begin
				n.role = ROLE_MASTER; // [RULE_14]
				n.pend_ann = 1'b1;
			end
		end
		// Peer delay runs in every role, untouched by Sync
		n.req_cnt = '0;
		if (cfg_p2p) begin
			n.req_cnt = s.req_cnt + 32'h0000_0001;
			if (s.req_cnt >= 32'(PDELAY_CYC - 1)) begin
				n.req_cnt = '0;
				n.pend_preq = 1'b1; // [RULE_05] [RULE_08]
			end
		end

		// ==========================================
		// Received messages; stamp comes from the preceding delimiter strobe
		if (rx_msg_valid) begin
			case (rx_msg_type)
				MSG_ANNOUNCE: begin
					if (rx_msg_quality < cfg_quality) begin
						n.role = ROLE_SLAVE; // [RULE_14] [RULE_16]
						n.tout_cnt = '0;
						n.pend_ann = 1'b0;
						n.pend_sync = 1'b0;
						// A Sync or Announce picked in this same cycle must not go out
						if (s.txp == TX_IDLE && (n.tx_type == MSG_SYNC || n.tx_type == MSG_ANNOUNCE)) begin
							n.txp = TX_IDLE; // [RULE_15]
						end
					end
				end
				MSG_SYNC: begin
					if (s.role == ROLE_SLAVE) begin
						n.sync_rx_time = s.rx_stamp; // [RULE_02]
						n.sync_seq = rx_msg_seq;
						n.wait_fu = rx_msg_two_step; // [RULE_13]
						if (!rx_msg_two_step) begin
							n.sync_tx_time = rx_msg_ts;
							sync_pair = 1'b1;
						end
					end
				end
				MSG_FOLLOW_UP: begin
					if (s.role == ROLE_SLAVE && s.wait_fu && rx_msg_seq == s.sync_seq) begin
						n.sync_tx_time = rx_msg_ts; // [RULE_02] [RULE_13]
						n.wait_fu = 1'b0;
						sync_pair = 1'b1;
					end
				end
				MSG_DELAY_REQ: begin
					if (s.role == ROLE_MASTER && !cfg_p2p) begin
						n.resp_ts = s.rx_stamp; // [RULE_04]
						n.resp_seq = rx_msg_seq;
						n.pend_dresp = 1'b1;
					end
				end
				MSG_DELAY_RESP: begin
					if (s.role == ROLE_SLAVE && !cfg_p2p && rx_msg_seq == s.req_seq) begin
						n.delay_req_rx_time = rx_msg_ts;
						e2e_done = 1'b1;
					end
				end
				MSG_PDELAY_REQ: begin
					if (cfg_p2p) begin
						n.resp_ts = s.rx_stamp; // [RULE_06]
						n.resp_seq = rx_msg_seq;
						n.pend_presp = 1'b1;
					end
				end
				MSG_PDELAY_RESP: begin
					if (cfg_p2p && rx_msg_seq == s.req_seq) begin
						n.pdelay_resp_rx_time = s.rx_stamp; // [RULE_07]
						n.delay_req_rx_time = rx_msg_ts;
						n.wait_pfu = rx_msg_two_step; // [RULE_13]
						n.pdelay_resp_tx_time = rx_msg_ts2;
						p2p_done = !rx_msg_two_step;
					end
				end
				MSG_PDELAY_RESP_FU: begin
					if (cfg_p2p && s.wait_pfu && rx_msg_seq == s.req_seq) begin
						n.pdelay_resp_tx_time = rx_msg_ts; // [RULE_13]
						n.wait_pfu = 1'b0;
						p2p_done = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// ==========================================
		// Delay
		if (e2e_done) begin
			n.delay = ptpsy_half_span(n.delay_req_rx_time, n.sync_tx_time,
				n.delay_req_tx_time, n.sync_rx_time); // [RULE_09]
			n.delay_ok = 1'b1;
		end
		if (p2p_done) begin
			n.delay = ptpsy_half_span(n.pdelay_resp_rx_time, n.delay_req_tx_time,
				n.pdelay_resp_tx_time, n.delay_req_rx_time); // [RULE_10] [RULE_08]
			n.delay_ok = 1'b1;
		end

		// ==========================================
		// Offset on every completed Sync pair; drift once a previous pair exists and the divider is idle
		if (sync_pair) begin
			n.offset = (n.sync_rx_time - n.sync_tx_time) - s.delay; // [RULE_11]
			n.phase_adj = 1'b1;
			n.pend_dreq = !cfg_p2p; // [RULE_03]
			if (s.have_prev && !s.div_busy) begin
				span_diff = 33'(signed'(32'(n.sync_rx_time - s.prev_sync_rx_time)))
					- 33'(signed'(32'(n.sync_tx_time - s.prev_sync_tx_time))); // [RULE_12]
				n.div_neg = span_diff[32];
				span_mag = span_diff[32] ? 33'(-span_diff) : 33'(span_diff);
				n.div_den = 32'(n.sync_tx_time - s.prev_sync_tx_time);
				if (n.div_den == 32'h0000_0000 || span_mag >= {1'b0, n.div_den}) begin
					// Out of range: saturate rather than divide
					n.drift = span_diff[32] ? 32'sh8000_0001 : 32'sh7FFF_FFFF;
					n.freq_adj = 1'b1;
				end else begin
					n.div_rem = span_mag;
					n.div_q = '0;
					n.div_cnt = '0;
					n.div_busy = 1'b1;
				end
			end
			n.have_prev = 1'b1;
			n.prev_sync_tx_time = n.sync_tx_time;
			n.prev_sync_rx_time = n.sync_rx_time;
		end

		// One quotient bit per cycle; cheaper than a wide combinational divide
		if (s.div_busy) begin
			rem2 = {s.div_rem[31:0], 1'b0};
			if (rem2 >= {1'b0, s.div_den}) begin
				n.div_rem = rem2 - {1'b0, s.div_den};
				n.div_q = {s.div_q[30:0], 1'b1};
			end else begin
				n.div_rem = rem2;
				n.div_q = {s.div_q[30:0], 1'b0};
			end
			n.div_cnt = s.div_cnt + 6'h01;
			if (s.div_cnt == 6'(DRIFT_FRAC_W - 1)) begin
				n.div_busy = 1'b0;
				n.drift = s.div_neg ? -signed'(n.div_q) : signed'(n.div_q); // [RULE_12]
				n.freq_adj = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ==========================================
	// Outputs
	assign tx_msg_valid = (s.txp == TX_OFFER);
	assign tx_msg_type = s.tx_type;
	assign tx_msg_seq = s.tx_seq;
	assign tx_msg_ts = s.tx_ts;
	assign tx_msg_two_step = s.tx_two;
	assign tx_onfly_ts = s.onfly_ts;
	assign tx_onfly_valid = s.onfly_valid;
	assign is_master = (s.role == ROLE_MASTER);
	assign path_delay = s.delay;
	assign delay_valid = s.delay_ok;
	assign phase_offset = s.offset;
	assign phase_adj = s.phase_adj;
	assign drift = s.drift;
	assign freq_adj = s.freq_adj;

endmodule

// File: hdl/ptpsy_pkg.sv
// What this block does
// [RULE_01] As master, stamp each Sync at send; insert on the fly or send Follow_Up.
// [RULE_02] As slave, stamp each arriving Sync and pair it with master's send time.
// [RULE_03] End-to-end slave sends Delay_Req and keeps its send stamp.
// [RULE_04] End-to-end master stamps each Delay_Req and returns it in Delay_Resp.
// [RULE_05] Peer mode requester sends Pdelay_Req to neighbour and keeps its send stamp.
// [RULE_06] Responder stamps Pdelay_Req, answers with it, stamps answer, one- or two-step.
// [RULE_07] Requester stamps arriving Pdelay_Resp, completing four peer-delay values.
// [RULE_08] Peer delay is measured by every node alike, regardless of Sync or role.
// [RULE_09] End-to-end delay is master span minus slave span, halved.
// [RULE_10] Peer delay is round trip minus responder turnaround, halved.
// [RULE_11] Offset is Sync receive minus Sync send minus delay; phase fixed each Sync.
// [RULE_12] Drift is slave interval minus master interval over master interval.
// [RULE_13] Both one-step and two-step received formats are handled.
// [RULE_14] Announce until a better clock is heard; resume after announce timeout.
// [RULE_15] The announcing node is master and sends periodic Sync.
// [RULE_16] Master role follows clock quality comparison; Announce and Sync are periodic.
// [RULE_17] All stamps are taken at the start-of-frame delimiter strobes.
package ptpsy_pkg;

	// ==========================================
	// Widths
	localparam int TS_W = 64;
	localparam int SEQ_W = 16;
	localparam int QUAL_W = 8;
	localparam int CNT_W = 32;
	localparam int DRIFT_FRAC_W = 31;

	typedef logic signed [TS_W-1:0] ptpsy_ts_t;

	// ==========================================
	// Message type codes as carried in the header
	typedef enum logic [3:0] {
		MSG_SYNC = 4'h0,
		MSG_DELAY_REQ = 4'h1,
		MSG_PDELAY_REQ = 4'h2,
		MSG_PDELAY_RESP = 4'h3,
		MSG_FOLLOW_UP = 4'h8,
		MSG_DELAY_RESP = 4'h9,
		MSG_PDELAY_RESP_FU = 4'hA,
		MSG_ANNOUNCE = 4'hB
	} ptpsy_msg_t;

	// ==========================================
	// States
	typedef enum logic {ROLE_SLAVE, ROLE_MASTER} ptpsy_role_t;
	typedef enum logic [1:0] {TX_IDLE, TX_OFFER, TX_STAMP} ptpsy_txp_t;

	// ==========================================
	// Timing
	localparam longint CLK_PERIOD_NS = 64'h0000_0000_0000_0008;
	localparam longint SYNC_PERIOD_NS = 64'h0000_0000_0773_5940;
	localparam longint ANNOUNCE_PERIOD_NS = 64'h0000_0000_3B9A_CA00;
	localparam longint ANNOUNCE_TIMEOUT_NS = 64'h0000_0000_B2D0_5E00;
	localparam longint PDELAY_PERIOD_NS = 64'h0000_0000_3B9A_CA00;
	localparam int unsigned SYNC_PERIOD_CYC = 32'(SYNC_PERIOD_NS / CLK_PERIOD_NS);
	localparam int unsigned ANNOUNCE_PERIOD_CYC = 32'(ANNOUNCE_PERIOD_NS / CLK_PERIOD_NS);
	localparam int unsigned ANNOUNCE_TIMEOUT_CYC = 32'((ANNOUNCE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int unsigned PDELAY_PERIOD_CYC = 32'(PDELAY_PERIOD_NS / CLK_PERIOD_NS);

	// ==========================================
	// Reset values
	localparam logic [SEQ_W-1:0] SEQ_RESET = 16'h0000;
	localparam ptpsy_ts_t TS_RESET = 64'h0000_0000_0000_0000;

	// Half of the difference between two spans, shared by both delay mechanisms
	function automatic ptpsy_ts_t ptpsy_half_span(input ptpsy_ts_t a_end, input ptpsy_ts_t a_start,
		input ptpsy_ts_t b_end, input ptpsy_ts_t b_start);
		ptpsy_half_span = ((a_end - a_start) - (b_end - b_start)) >>> 1;
	endfunction

endpackage

// File: tb/ptpsy_sync_engine_sva.sv
`timescale 1ns/1ps
// ==========
// Port checker
module ptpsy_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Inputs
	input wire ptpsy_pkg::ptpsy_ts_t local_time,
	input wire logic cfg_p2p,
	input wire logic cfg_master_capable,
	input wire logic tx_sfd,
	input wire logic rx_msg_valid,
	input wire ptpsy_pkg::ptpsy_msg_t rx_msg_type,
	input wire logic tx_msg_ready,
	// Outputs
	input wire logic tx_msg_valid,
	input wire ptpsy_pkg::ptpsy_msg_t tx_msg_type,
	input wire logic [ptpsy_pkg::SEQ_W-1:0] tx_msg_seq,
	input wire ptpsy_pkg::ptpsy_ts_t tx_msg_ts,
	input wire ptpsy_pkg::ptpsy_ts_t tx_onfly_ts,
	input wire logic tx_onfly_valid,
	input wire logic is_master,
	input wire ptpsy_pkg::ptpsy_ts_t path_delay,
	input wire logic delay_valid,
	input wire logic phase_adj,
	input wire logic freq_adj
);
	import ptpsy_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	offer_hold_a: assert property (tx_msg_valid && !tx_msg_ready |=> tx_msg_valid && $stable(tx_msg_type) &&
		$stable(tx_msg_seq) && $stable(tx_msg_ts)) else $error("offer changed before accept");
	stamp_time_a: assert property (tx_onfly_valid |-> $past(tx_sfd) && tx_onfly_ts == $past(local_time))
		else $error("send stamp not taken at delimiter");
	stamp_pulse_a: assert property (tx_onfly_valid |=> !tx_onfly_valid) else $error("stamp strobe too long");
	phase_cause_a: assert property (phase_adj |-> $past(rx_msg_valid) && !$past(is_master) &&
		($past(rx_msg_type) inside {MSG_SYNC, MSG_FOLLOW_UP})) else $error("phase step without sync");
	delay_cause_a: assert property (!$stable(path_delay) |-> $past(rx_msg_valid) &&
		($past(rx_msg_type) inside {MSG_DELAY_RESP, MSG_PDELAY_RESP, MSG_PDELAY_RESP_FU})) else $error("delay moved");
	delay_sticky_a: assert property (delay_valid |=> delay_valid) else $error("delay valid dropped");
	sync_master_a: assert property (tx_msg_valid && !$past(tx_msg_valid) && tx_msg_type == MSG_SYNC |-> is_master)
		else $error("sync offered by slave");
	dreq_mode_a: assert property (tx_msg_valid && tx_msg_type == MSG_DELAY_REQ |-> !cfg_p2p)
		else $error("delay request in peer mode");
	master_cap_a: assert property (is_master |-> cfg_master_capable) else $error("master while incapable");
	freq_pulse_a: assert property (freq_adj |=> !freq_adj) else $error("frequency strobe too long");
	cover property (phase_adj);
	cover property ($rose(delay_valid));
	cover property (tx_onfly_valid && tx_msg_type == MSG_SYNC);
endmodule

bind ptpsy_sync_engine ptpsy_chk chk (.*);

// File: tb/ptpsy_peer_model.sv
`timescale 1ns/1ps
// ==========
// Far-side node
module ptpsy_peer (
	// Clock and stall control
	input wire logic clock,
	input wire logic slow,
	input wire ptpsy_pkg::ptpsy_ts_t local_time,
	// Frames toward the device
	output logic rx_sfd,
	output logic rx_msg_valid,
	output ptpsy_pkg::ptpsy_msg_t rx_msg_type,
	output logic [ptpsy_pkg::SEQ_W-1:0] rx_msg_seq,
	output ptpsy_pkg::ptpsy_ts_t rx_msg_ts,
	output ptpsy_pkg::ptpsy_ts_t rx_msg_ts2,
	output logic rx_msg_two_step,
	output logic [ptpsy_pkg::QUAL_W-1:0] rx_msg_quality,
	// Frames from the device
	input wire logic tx_msg_valid,
	input wire ptpsy_pkg::ptpsy_msg_t tx_msg_type,
	input wire logic [ptpsy_pkg::SEQ_W-1:0] tx_msg_seq,
	input wire ptpsy_pkg::ptpsy_ts_t tx_msg_ts,
	output logic tx_msg_ready,
	output logic tx_sfd
);
	import ptpsy_pkg::*;
	initial begin
		{rx_sfd, rx_msg_valid, rx_msg_two_step, tx_msg_ready, tx_sfd} = 5'h00;
		rx_msg_type = MSG_SYNC;
		rx_msg_seq = 16'h0000;
		rx_msg_ts = '0;
		rx_msg_ts2 = '0;
		rx_msg_quality = 8'h00;
	end
	// ==========
	// Delimiter, then fields for one cycle; stamp is the device's receive time
	task automatic send(input ptpsy_msg_t ty, input logic [SEQ_W-1:0] sq, input ptpsy_ts_t a, input ptpsy_ts_t b,
		input logic two, input logic [QUAL_W-1:0] q, output ptpsy_ts_t stamp);
		@(posedge clock);
		#1;
		rx_sfd = 1'b1;
		stamp = local_time;
		@(posedge clock);
		#1;
		rx_sfd = 1'b0;
		rx_msg_valid = 1'b1;
		rx_msg_type = ty;
		rx_msg_seq = sq;
		rx_msg_ts = a;
		rx_msg_ts2 = b;
		rx_msg_two_step = two;
		rx_msg_quality = q;
		@(posedge clock);
		#1;
		rx_msg_valid = 1'b0;
		// Fields belong to no frame now; a late read sees garbage
		rx_msg_ts = ~a;
		rx_msg_ts2 = ~b;
	endtask
	// ==========
	// Accept an offer (late when stalling), then mark its delimiter
	task automatic take(output logic ok, output ptpsy_msg_t ty, output logic [SEQ_W-1:0] sq, output ptpsy_ts_t ts);
		int n;
		ok = 1'b0;
		for (n = 0; n < 400 && !ok; n++) begin
			@(posedge clock);
			#1;
			ok = (tx_msg_valid === 1'b1);
		end
		ty = tx_msg_type;
		sq = tx_msg_seq;
		ts = tx_msg_ts;
		if (slow) begin
			repeat (3) @(posedge clock);
			#1;
		end
		tx_msg_ready = ok;
		@(posedge clock);
		#1;
		tx_msg_ready = 1'b0;
		if (slow) begin
			repeat (4) @(posedge clock);
			#1;
		end
		tx_sfd = ok;
		@(posedge clock);
		#1;
		tx_sfd = 1'b0;
	endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
// ==========
// Bench top
module tb;
	import ptpsy_pkg::*;
	logic clock, reset, cfg_p2p, cfg_master_capable, cfg_two_step, slow, rx_sfd, tx_sfd, rx_msg_valid;
	logic rx_msg_two_step, tx_msg_valid, tx_msg_ready, tx_msg_two_step, tx_onfly_valid, is_master;
	logic delay_valid, phase_adj, freq_adj;
	logic [QUAL_W-1:0] cfg_quality, rx_msg_quality;
	ptpsy_ts_t local_time, rx_msg_ts, rx_msg_ts2, tx_msg_ts, tx_onfly_ts, path_delay, phase_offset, t1a, t2a;
	ptpsy_msg_t rx_msg_type, tx_msg_type, ty;
	logic [SEQ_W-1:0] rx_msg_seq, tx_msg_seq, sq;
	logic signed [31:0] drift;
	int failures = 0;
	int checks_done = 0;
	ptpsy_sync_engine #(.SYNC_CYC(32'h0000_0014), .ANNOUNCE_CYC(32'h0000_0028), .TIMEOUT_CYC(32'h0000_0096),
		.PDELAY_CYC(32'h0000_003C)) dut (.*);
	ptpsy_peer peer (.*);
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial local_time = 64'h0000_0000_0001_0000;
	always @(posedge clock) local_time <= local_time + 16'h0008;
	// ==========
	// Shared helpers
	task automatic test_done();
		$display("failures %0d checks %0d", failures, checks_done);
		if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic hang();
		failures++;
		$display("unexpected at %0t: wait ran out", $time);
		test_done();
	endtask
	task automatic check(input ptpsy_ts_t got, input ptpsy_ts_t exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	// Bounded wait on the master flag (sel) or the frequency strobe
	task automatic wait_hi(input bit sel, input int lim);
		int n;
		for (n = 0; n < lim && (sel ? is_master : freq_adj) !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		if ((sel ? is_master : freq_adj) !== 1'b1) hang();
	endtask
	task automatic serve(output ptpsy_ts_t ts);
		logic ok;
		peer.take(ok, ty, sq, ts);
		if (!ok) hang();
	endtask
	task automatic do_reset();
		@(posedge clock);
		#1;
		reset = 1'b1;
		repeat (10) @(posedge clock);
		#1;
		reset = 1'b0;
	endtask
	// ==========
	// Scenarios
	task automatic sc_e2e();
		ptpsy_ts_t ts, t4;
		t1a = 64'h0000_0000_0000_1000;
		peer.send(MSG_SYNC, 16'h0001, t1a, '0, 1'b0, 8'h00, t2a);
		check(phase_adj, 1'b1);
		check(phase_offset, t2a - t1a);
		serve(ts);
		check(ty, MSG_DELAY_REQ);
		t4 = t1a + (tx_onfly_ts - t2a) + 16'h0190;
		peer.send(MSG_DELAY_RESP, sq + 16'h0001, t4, '0, 1'b0, 8'h00, ts);
		check(delay_valid, 1'b0);
		peer.send(MSG_DELAY_RESP, sq, t4, '0, 1'b0, 8'h00, ts);
		check(delay_valid, 1'b1);
		check(path_delay, 16'h00C8);
	endtask
	task automatic sc_drift();
		ptpsy_ts_t t2, ts;
		int n;
		for (n = 0; n < 400 && local_time !== t2a + 16'h03E0; n++) begin
			@(posedge clock);
			#1;
		end
		if (n == 400) hang();
		peer.send(MSG_SYNC, 16'h0002, ~t1a, '0, 1'b1, 8'h00, t2);
		check(phase_adj, 1'b0);
		peer.send(MSG_FOLLOW_UP, 16'h0003, t1a + 16'h0320, '0, 1'b0, 8'h00, ts);
		check(phase_adj, 1'b0);
		peer.send(MSG_FOLLOW_UP, 16'h0002, t1a + 16'h0320, '0, 1'b0, 8'h00, ts);
		check(phase_adj, 1'b1);
		check(phase_offset, t2 - t1a - 16'h0320 - 16'h00C8);
		wait_hi(1'b0, 40);
		check(drift, 32'h2000_0000);
	endtask
	task automatic sc_p2p();
		ptpsy_ts_t ts, t3, t4, t6;
		// Switch mode only once reset has dropped the Delay_Req still on offer
		do_reset();
		cfg_p2p = 1'b1;
		slow = 1'b1;
		serve(ts);
		check(ty, MSG_PDELAY_REQ);
		t3 = tx_onfly_ts;
		repeat (6) @(posedge clock);
		peer.send(MSG_PDELAY_RESP, sq, 16'h5000, 16'h5010, 1'b0, 8'h00, t6);
		check(delay_valid, 1'b1);
		check(path_delay, ((t6 - t3) - 16'h0010) >>> 1);
		slow = 1'b0;
		cfg_two_step = 1'b1;
		peer.send(MSG_PDELAY_REQ, 16'h0033, '0, '0, 1'b0, 8'h00, t4);
		serve(ts);
		check(ty, MSG_PDELAY_RESP);
		check(tx_msg_two_step, 1'b1);
		check(ts, t4);
		t3 = tx_onfly_ts;
		serve(ts);
		check(ty, MSG_PDELAY_RESP_FU);
		check(sq, 16'h0033);
		check(ts, t3);
	endtask
	task automatic sc_role();
		ptpsy_ts_t ts, st, t4;
		int n, seen;
		cfg_p2p = 1'b0;
		cfg_master_capable = 1'b1;
		do_reset();
		wait_hi(1'b1, 200);
		seen = 0;
		st = '0;
		for (n = 0; n < 6; n++) begin
			serve(ts);
			if (ty == MSG_SYNC) begin
				seen |= 1;
				st = tx_onfly_ts;
			end
			if (ty == MSG_FOLLOW_UP) check(ts, st);
			if (ty == MSG_ANNOUNCE) seen |= 2;
		end
		check(seen, 3);
		peer.send(MSG_DELAY_REQ, 16'h0044, '0, '0, 1'b0, 8'h00, t4);
		for (n = 0; n < 4 && ty !== MSG_DELAY_RESP; n++) serve(ts);
		check(sq, 16'h0044);
		check(ts, t4);
		peer.send(MSG_ANNOUNCE, 16'h0001, '0, '0, 1'b0, 8'h40, ts);
		for (n = 0; n < 8 && is_master !== 1'b0; n++) begin
			@(posedge clock);
			#1;
		end
		check(is_master, 1'b0);
	endtask
	initial begin
		{reset, cfg_p2p, cfg_master_capable, cfg_two_step, slow} = 5'h10;
		cfg_quality = 8'h80;
		do_reset();
		sc_e2e();
		sc_drift();
		sc_p2p();
		sc_role();
		test_done();
	end
endmodule
